/* logic/tsp_defines.svh */
// Purpose: Constants for the fetch/execute pipeline controller
// Assumes: Four phases per instruction cycle
// Notes:   Included by the package and the design modules
`ifndef TSP_DEFINES_SVH
`define TSP_DEFINES_SVH

`define TSP_PHASES        4
`define TSP_PC_W          14
`define TSP_INSTR_W       16
`define TSP_DATA_W        8
`define TSP_PAGE_W        8
`define TSP_PC_RESET      14'h0000
`define TSP_ACC_RESET     8'h00
`define TSP_NOP_WORD      16'h0000
// Opcode field: bits 15:12
`define TSP_OP_MSB        15
`define TSP_OP_LSB        12
`define TSP_ARG_W         12
`define TSP_RF_DEPTH      16
`define TSP_RF_AW         4

`endif

/* logic/tsp_pipeline.sv */
// Purpose: Two-stage fetch/execute pipeline sequencer for an 8-bit core
// Assumes: Program memory answers within one phase; inputs synchronous to CLK_SYS
// Notes:   Opcode in bits 15:12, 12-bit argument; EXT takes a second word
`include "tsp_defines.svh"

// How it works
// - The system clock is divided into four one-hot non-overlapping phases, one set per instruction cycle.
// - At the start of phase one the program counter advances and a new instruction fetch begins.
// - Phases two to four decode and execute the instruction fetched in the previous cycle.
// - Fetch of the next instruction overlaps execution of the current one, giving one cycle per plain instruction.
// - Standard instructions take one instruction cycle and extended ones take two without a branch.
// - Any instruction that changes the program counter takes one extra instruction cycle.
// - A jump or call takes two machine cycles: one to obtain the target, one to transfer control.
// - Arithmetic, logic, rotate, increment, decrement and skip decisions use one 8-bit datapath.
// - Operands move through the accumulator and ALU, with registers in data memory reached directly by the low four argument bits.
// - A taken conditional skip discards the prefetched instruction and runs a dummy cycle instead.
// - Writing the program counter low byte branches within the 256-word page and inserts a dummy cycle.
module tsp_pipeline
  import tsp_pkg::*;
#(
  parameter int PC_W    = `TSP_PC_W,
  parameter int INSTR_W = `TSP_INSTR_W,
  parameter int DATA_W  = `TSP_DATA_W
) (
  // Clock and reset
  input  wire logic               CLK_SYS,
  input  wire logic               SYS_RST,
  // Program memory fetch path
  input  wire logic [INSTR_W-1:0] PM_RDATA,
  output logic      [PC_W-1:0]    PM_ADDR,
  output logic                    PM_FETCH,
  // Phase clocks
  output logic      [3:0]         INSTRUCTION_PHASE_CLOCKS,
  // Execution status
  output logic      [DATA_W-1:0]  ACC,
  output logic                    INSTR_RETIRE,
  output logic                    FLUSH,
  output logic                    SKIP_ZERO
);

  // ------------------------------------------------------------
  // Phase generator
  // ------------------------------------------------------------
  tsp_phase_t phase_reg;
  tsp_phase_t phase_next;

  if (PC_W <= `TSP_PAGE_W || DATA_W != `TSP_DATA_W || INSTR_W != `TSP_INSTR_W) begin : g_bad_width
    $error("tsp_pipeline: unsupported widths");
  end

  always_comb begin
    case (phase_reg)
      PH_T1:   phase_next = PH_T2;
      PH_T2:   phase_next = PH_T3;
      PH_T3:   phase_next = PH_T4;
      PH_T4:   phase_next = PH_T1;
      default: phase_next = PH_T1;
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      phase_reg <= PH_T4;
    end else begin
      phase_reg <= phase_next;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      INSTRUCTION_PHASE_CLOCKS <= 4'h0;
    end else begin
      INSTRUCTION_PHASE_CLOCKS <= 4'h1 << phase_next;
    end
  end

  // ------------------------------------------------------------
  // Decode helpers
  // ------------------------------------------------------------
  function automatic tsp_op_t op_of(input logic [INSTR_W-1:0] w);
    op_of = tsp_op_t'(w[`TSP_OP_MSB:`TSP_OP_LSB]);
  endfunction : op_of

  function automatic logic is_branch(input tsp_op_t op);
    is_branch = (op == OP_JMP) || (op == OP_CALL);
  endfunction : is_branch

  // ------------------------------------------------------------
  // Fetch stage
  // ------------------------------------------------------------
  logic [PC_W-1:0]    pc_reg;
  logic [INSTR_W-1:0] ir_reg;      // Instruction latched for execution
  logic [INSTR_W-1:0] fetch_reg;   // Word being fetched this cycle
  logic               ext_reg;     // Executing word is operand of extended op
  logic               dummy_reg;   // Executing cycle is a dummy
  logic               redirect;
  logic [PC_W-1:0]    target;
  logic               start_t1;

  assign start_t1 = (phase_next == PH_T1);

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      pc_reg   <= `TSP_PC_RESET;
      PM_ADDR  <= `TSP_PC_RESET;
      PM_FETCH <= 1'b0;
    end else begin
      PM_FETCH <= start_t1;
      if (start_t1) begin
        if (redirect) begin
          PM_ADDR <= target;
          pc_reg  <= PC_W'(target + 1'b1);
        end else begin
          PM_ADDR <= pc_reg;
          pc_reg  <= PC_W'(pc_reg + 1'b1);
        end
      end
    end
  end

  // Capture fetched word at end of T1 into pipeline register at T4
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      fetch_reg <= `TSP_NOP_WORD;
    end else if (phase_reg == PH_T1) begin
      fetch_reg <= PM_RDATA;
    end
  end

  // ------------------------------------------------------------
  // Execute stage
  // ------------------------------------------------------------
  tsp_op_t             op;
  logic [DATA_W-1:0]   alu_res;
  logic [DATA_W-1:0]   opnd;
  logic                skip_take;
  logic                rf_we;
  logic [DATA_W-1:0]   rf_rdata;
  logic [`TSP_RF_AW-1:0] rf_addr;

  assign op      = op_of(ir_reg);
  assign rf_addr = ir_reg[`TSP_RF_AW-1:0];
  assign opnd    = rf_rdata;

  // Branch decision and redirect at T4 of a valid execute cycle
  always_comb begin
    redirect  = 1'b0;
    skip_take = 1'b0;
    target    = pc_reg;
    if (phase_reg == PH_T4 && !dummy_reg && !ext_reg) begin
      if (is_branch(op)) begin
        redirect = 1'b1;
        target   = PC_W'(ir_reg[`TSP_ARG_W-1:0]);
      end else if (op == OP_WPCL) begin
        redirect = 1'b1;
        target   = {pc_reg[PC_W-1:`TSP_PAGE_W], ACC};
      end else if (op == OP_SZ && opnd == '0) begin
        skip_take = 1'b1;
      end
    end
  end

  // ALU: one 8-bit datapath for every operation
  always_comb begin
    case (op)
      OP_MOVA: alu_res = opnd;
      OP_ADD:  alu_res = DATA_W'(ACC + opnd);
      OP_AND:  alu_res = ACC & opnd;
      OP_XOR:  alu_res = ACC ^ opnd;
      OP_ORA:  alu_res = ACC | opnd;
      OP_RL:   alu_res = {ACC[DATA_W-2:0], ACC[DATA_W-1]};
      OP_INC:  alu_res = DATA_W'(ACC + 1'b1);
      OP_DEC:  alu_res = DATA_W'(ACC - 1'b1);
      OP_LDI:  alu_res = ir_reg[DATA_W-1:0];
      default: alu_res = ACC;
    endcase
  end

  logic acc_op;
  assign acc_op = (op != OP_MOVM) && (op != OP_SZ) && (op != OP_NOP) && !is_branch(op)
                  && (op != OP_WPCL) && (op != OP_EXT);

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      ACC <= `TSP_ACC_RESET;
    end else if (phase_reg == PH_T3 && !dummy_reg && !ext_reg && acc_op) begin
      ACC <= alu_res;
    end
  end

  assign rf_we = (phase_reg == PH_T3) && !dummy_reg && !ext_reg && (op == OP_MOVM);

  logic [DATA_W-1:0] rf_data_unused_guard;

  tsp_regfile #(
    .DEPTH (`TSP_RF_DEPTH),
    .AW    (`TSP_RF_AW),
    .DW    (DATA_W)
  ) u_rf (
    .clk     (CLK_SYS),
    .rst     (SYS_RST),
    .wr_en   (rf_we),
    .wr_addr (rf_addr),
    .wr_data (ACC),
    .rd_addr (rf_addr),
    .rd_data (rf_data_unused_guard)
  );
  assign rf_rdata = rf_data_unused_guard;

  // Load next instruction at end of cycle; flush or mark dummy as needed
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      ir_reg    <= `TSP_NOP_WORD;
      dummy_reg <= 1'b1;
      ext_reg   <= 1'b0;
      FLUSH     <= 1'b0;
      SKIP_ZERO <= 1'b0;
    end else if (phase_reg == PH_T4 && INSTRUCTION_PHASE_CLOCKS[3]) begin
      // Live T4 only: the edge leaving reset keeps the first cycle a dummy
      ir_reg    <= fetch_reg;
      FLUSH     <= redirect | skip_take;
      SKIP_ZERO <= skip_take;
      dummy_reg <= redirect | skip_take;
      ext_reg   <= !dummy_reg && !ext_reg && !redirect && !skip_take && (op == OP_EXT);
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      INSTR_RETIRE <= 1'b0;
    end else begin
      INSTR_RETIRE <= (phase_reg == PH_T4) && !dummy_reg && !ext_reg;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  sequence s_branch_t4;
    phase_reg == PH_T4 && redirect;
  endsequence

  a_phase_onehot: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    !$past(SYS_RST) |-> $onehot(INSTRUCTION_PHASE_CLOCKS)) else $error("phase not one-hot");
  a_phase_rotate: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    INSTRUCTION_PHASE_CLOCKS == 4'h1 |=> INSTRUCTION_PHASE_CLOCKS == 4'h2 ##1 INSTRUCTION_PHASE_CLOCKS == 4'h4
    ##1 INSTRUCTION_PHASE_CLOCKS == 4'h8) else $error("phase order broken");
  a_fetch_t1: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    PM_FETCH |-> INSTRUCTION_PHASE_CLOCKS == 4'h1) else $error("fetch outside T1");
  a_pc_step: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    PM_FETCH |-> pc_reg == PC_W'(PM_ADDR + 1'b1)) else $error("pc not advanced");
  a_acc_phase: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    $changed(ACC) |-> $past(phase_reg) == PH_T3) else $error("acc written outside execute");
  a_branch_flush: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    s_branch_t4 |=> FLUSH && dummy_reg) else $error("branch did not flush");
  a_branch_target: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    s_branch_t4 |=> PM_FETCH && PM_ADDR == $past(target)) else $error("wrong branch target");
  a_dummy_noretire: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    s_branch_t4 |=> ##4 !INSTR_RETIRE) else $error("dummy cycle retired");
  a_skip_dummy: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    phase_reg == PH_T4 && skip_take |=> SKIP_ZERO && dummy_reg) else $error("skip without dummy");
  a_pcl_page: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    phase_reg == PH_T4 && redirect && op == OP_WPCL |=>
    PM_ADDR[PC_W-1:`TSP_PAGE_W] == $past(pc_reg[PC_W-1:`TSP_PAGE_W]) && PM_ADDR[`TSP_PAGE_W-1:0] == $past(ACC))
    else $error("pcl write left page");

endmodule : tsp_pipeline

/* logic/tsp_pkg.sv */
// Purpose: Types for the fetch/execute pipeline controller
// Assumes: tsp_defines.svh supplies all numbers
// Notes:   Opcode set is a compact stand-in for the real instruction set
`include "tsp_defines.svh"

package tsp_pkg;

  typedef enum logic [3:0] {
    OP_NOP   = 4'h0,
    OP_MOVA  = 4'h1,
    OP_MOVM  = 4'h2,
    OP_ADD   = 4'h3,
    OP_AND   = 4'h4,
    OP_XOR   = 4'h5,
    OP_RL    = 4'h6,
    OP_INC   = 4'h7,
    OP_DEC   = 4'h8,
    OP_SZ    = 4'h9,
    OP_JMP   = 4'hA,
    OP_CALL  = 4'hB,
    OP_LDI   = 4'hC,
    OP_WPCL  = 4'hD,
    OP_EXT   = 4'hE,
    OP_ORA   = 4'hF
  } tsp_op_t;

  typedef enum {
    PH_T1,
    PH_T2,
    PH_T3,
    PH_T4
  } tsp_phase_t;

endpackage : tsp_pkg

/* logic/tsp_regfile.sv */
// Purpose: Small data memory holding operand registers
// Assumes: One write and one registered read port
// Notes:   Read data come out of a register
`include "tsp_defines.svh"

module tsp_regfile
  import tsp_pkg::*;
#(
  parameter int DEPTH = `TSP_RF_DEPTH,
  parameter int AW    = `TSP_RF_AW,
  parameter int DW    = `TSP_DATA_W
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          rst,
  // Write port
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [DW-1:0] wr_data,
  // Read port
  input  wire logic [AW-1:0] rd_addr,
  output logic      [DW-1:0] rd_data
);

  logic [DW-1:0] mem_reg [DEPTH];

  if (DEPTH != (1 << AW)) begin : g_bad_depth
    $error("tsp_regfile: DEPTH must be 2**AW");
  end

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem_reg[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rd_data <= '0;
    end else begin
      rd_data <= mem_reg[rd_addr];
    end
  end

endmodule : tsp_regfile

/* tb/tsp_pmem_model.sv */
// Purpose: Program memory seen from the fetch path
// Assumes: Word answered combinationally while the fetch strobe is high
// Notes:   Outside a fetch the bus shows the inverse of the last word
module tsp_pmem_model (
  // Clock
  input  wire logic        clk,
  // Fetch path
  input  wire logic [13:0] pm_addr,
  input  wire logic        pm_fetch,
  output logic      [15:0] pm_rdata
);
  logic [15:0] mem [0:16383];
  logic [15:0] last_reg = 16'h0000;

  always_comb pm_rdata = pm_fetch ? mem[pm_addr] : ~last_reg;

  always_ff @(posedge clk) begin
    if (pm_fetch) last_reg <= mem[pm_addr];
  end
endmodule : tsp_pmem_model

/* tb/two_stage_fetch_execute_pipeline_tb.sv */
// Purpose: Bench for the two-stage fetch/execute sequencer
// Assumes: Memory model answers in the fetch cycle
// Notes:   Each scenario reboots the core and logs 12 instruction cycles
`include "tsp_defines.svh"

module two_stage_fetch_execute_pipeline_tb import tsp_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk_sys;
  logic        sys_rst;
  logic [15:0] pm_rdata;
  logic [13:0] pm_addr;
  logic        pm_fetch;
  logic [3:0]  phases;
  logic [7:0]  acc;
  logic        retire;
  logic        flush;
  logic        skip_zero;
  int          checks = 0;
  int          miscompares = 0;
  int          flushes;
  int          skips;
  int          retires;
  logic [13:0] addrs[$];

  tsp_pipeline tsp_pipeline_i (
    .CLK_SYS(clk_sys), .SYS_RST(sys_rst), .PM_RDATA(pm_rdata), .PM_ADDR(pm_addr),
    .PM_FETCH(pm_fetch), .INSTRUCTION_PHASE_CLOCKS(phases), .ACC(acc),
    .INSTR_RETIRE(retire), .FLUSH(flush), .SKIP_ZERO(skip_zero)
  );

  tsp_pmem_model tsp_pmem_model_i (
    .clk(clk_sys), .pm_addr(pm_addr), .pm_fetch(pm_fetch), .pm_rdata(pm_rdata)
  );

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic results;
    $display("Checks %0d, mismatches %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : results

  task automatic clr;
    for (int a = 0; a < 16384; a++) tsp_pmem_model_i.mem[a] = `TSP_NOP_WORD;
  endtask : clr

  task automatic ld(input logic [13:0] a, input tsp_op_t op, input logic [11:0] arg);
    tsp_pmem_model_i.mem[a] = {op, arg};
  endtask : ld

  // Reboot, then log fetches and status over 48 clocks
  task automatic run;
    addrs = {};
    flushes = 0;
    skips = 0;
    retires = 0;
    @(posedge clk_sys);
    #2 sys_rst = 1'b1;
    repeat (10) @(posedge clk_sys);
    #2 chk("phases in reset", {12'h0000, phases}, 16'h0000);
    sys_rst = 1'b0;
    for (int i = 0; i < 48; i++) begin
      @(posedge clk_sys);
      #2 chk("phase", {12'h0000, phases}, 16'(1 << (i % 4)));
      chk("fetch strobe", {15'h0000, pm_fetch}, 16'(i % 4 == 0));
      if (pm_fetch === 1'b1) addrs.push_back(pm_addr);
      if (flush === 1'b1) flushes++;
      if (skip_zero === 1'b1) skips++;
      if (retire === 1'b1) retires++;
    end
  endtask : run

  task automatic verify(input logic [13:0] exp[8], input logic [7:0] acc_exp, input int f, input int s, input int r);
    for (int j = 0; j < 8; j++) chk("fetch address", {2'b00, addrs[j]}, {2'b00, exp[j]});
    chk("accumulator", {8'h00, acc}, {8'h00, acc_exp});
    chk("flush cycles", 16'(flushes), 16'(f));
    chk("skip cycles", 16'(skips), 16'(s));
    chk("retired", 16'(retires), 16'(r));
  endtask : verify

  task automatic t_jump;
    clr();
    ld(14'h0000, OP_LDI, 12'h05A);
    ld(14'h0001, OP_MOVM, 12'h001);
    ld(14'h0002, OP_LDI, 12'h003);
    ld(14'h0003, OP_ADD, 12'h001);
    ld(14'h0004, OP_JMP, 12'h008);
    ld(14'h0005, OP_LDI, 12'h0FF);
    ld(14'h0008, OP_INC, 12'h000);
    run();
    verify('{14'h0000, 14'h0001, 14'h0002, 14'h0003, 14'h0004, 14'h0005, 14'h0008,
             14'h0009}, 8'h5E, 4, 0, 9);
  endtask : t_jump

  task automatic t_skip;
    clr();
    ld(14'h0000, OP_LDI, 12'h000);
    ld(14'h0001, OP_MOVM, 12'h002);
    ld(14'h0002, OP_SZ, 12'h002);
    ld(14'h0003, OP_LDI, 12'h077);
    ld(14'h0004, OP_LDI, 12'h005);
    ld(14'h0005, OP_MOVM, 12'h003);
    ld(14'h0006, OP_SZ, 12'h003);
    ld(14'h0007, OP_INC, 12'h000);
    run();
    verify('{14'h0000, 14'h0001, 14'h0002, 14'h0003, 14'h0004, 14'h0005, 14'h0006,
             14'h0007}, 8'h06, 4, 4, 9);
  endtask : t_skip

  task automatic t_pcl;
    clr();
    ld(14'h0000, OP_JMP, 12'h105);
    ld(14'h0105, OP_LDI, 12'h009);
    ld(14'h0106, OP_WPCL, 12'h000);
    ld(14'h0107, OP_LDI, 12'h033);
    ld(14'h0109, OP_INC, 12'h000);
    run();
    verify('{14'h0000, 14'h0001, 14'h0105, 14'h0106, 14'h0107, 14'h0109, 14'h010A,
             14'h010B}, 8'h0A, 8, 0, 8);
  endtask : t_pcl

  task automatic t_ext;
    clr();
    ld(14'h0000, OP_LDI, 12'h011);
    ld(14'h0001, OP_EXT, 12'h000);
    ld(14'h0002, OP_INC, 12'h000);
    run();
    verify('{14'h0000, 14'h0001, 14'h0002, 14'h0003, 14'h0004, 14'h0005, 14'h0006,
             14'h0007}, 8'h11, 0, 0, 9);
  endtask : t_ext

  task automatic t_alu;
    clr();
    ld(14'h0000, OP_LDI, 12'h00C);
    ld(14'h0001, OP_MOVM, 12'h004);
    ld(14'h0002, OP_LDI, 12'h00A);
    ld(14'h0003, OP_AND, 12'h004);
    ld(14'h0004, OP_CALL, 12'h010);
    ld(14'h0005, OP_LDI, 12'h0FF);
    ld(14'h0010, OP_XOR, 12'h004);
    ld(14'h0011, OP_ORA, 12'h004);
    ld(14'h0012, OP_RL, 12'h000);
    ld(14'h0013, OP_MOVA, 12'h004);
    ld(14'h0014, OP_DEC, 12'h000);
    run();
    verify('{14'h0000, 14'h0001, 14'h0002, 14'h0003, 14'h0004, 14'h0005, 14'h0010,
             14'h0011}, 8'h0B, 4, 0, 9);
  endtask : t_alu

  initial begin
    sys_rst = 1'b1;
    t_jump();
    t_skip();
    t_pcl();
    t_ext();
    t_alu();
    results();
  end

  // Watchdog: five scenarios need about 7.4 us, well under the 20 us limit
  initial begin
    #20000;
    miscompares++;
    results();
  end
endmodule : two_stage_fetch_execute_pipeline_tb
